// File: src/rmss_defs.vh
// rmss_defs.vh: constants for the ramp-monitored stop block
// assumes a 100 MHz block clock; included by bare name
`ifndef RMSS_DEFS_VH
`define RMSS_DEFS_VH

// register offsets (byte addresses, word aligned)
`define RMSS_REG_CTRL        8'h00
`define RMSS_REG_STOP_TO     8'h04
`define RMSS_REG_DWELL       8'h08
`define RMSS_REG_ZWIN        8'h0C
`define RMSS_REG_DLIM        8'h10
`define RMSS_REG_DDLY        8'h14
`define RMSS_REG_FBREQ       8'h18
`define RMSS_REG_STATUS      8'h1C
`define RMSS_REG_IRQ_STAT    8'h20
`define RMSS_REG_IRQ_MASK    8'h24
`define RMSS_REG_OUTMAP      8'h28

// ctrl field positions
`define RMSS_CTRL_FB_EN      0
`define RMSS_CTRL_DUAL       1
`define RMSS_CTRL_USE_LSB    2
`define RMSS_CTRL_MON_LSB    5
`define RMSS_CTRL_FR_SEL     8

// reset values
`define RMSS_CTRL_RST        32'h0000_0104
`define RMSS_STOP_TO_MS      16'h0002
`define RMSS_DWELL_MS        16'h0001
`define RMSS_ZWIN_RST        16'h0001
`define RMSS_DLIM_RST        16'h0000
`define RMSS_DDLY_MS         16'h0001

// timing
`define RMSS_CLK_HZ          100000000
`define RMSS_MS_CYC          (`RMSS_CLK_HZ / 1000)
`define RMSS_DISC_MS         100

// irq bits
`define RMSS_IRQ_IOFAIL      0
`define RMSS_IRQ_TO_LSB      1
`define RMSS_IRQ_DV_LSB      4

`endif

// File: src/rmss_top.v
// rmss_top.v: three controlled-stop monitors for one axis with a register port
// assumes synchronous inputs on mclk and a one-cycle-read register master
`include "rmss_defs.vh"

// Overview of operation
// - dual-input mismatch over 100 ms trips instance 1
// - discrepancy failure raises warning output
// - fault reactions can trigger instance 1
// - active status reaches safe_out only when mapped
// - active monitor supervises deceleration until torque off
// - velocity in zero window for dwell: early torque_off
// - stop timeout forces torque off, default 2 ms
// - deceleration beyond limit is a violation
// - deceleration check starts after monitor delay
// - three independent instances per axis
// - request sources: fieldbus, fault, inputs, discrepancy
// - each instance shows active and torque_off flags
// - ramp monitoring only when enabled, else timed
// - unused instance 2 or 3 ignores fieldbus bit
// - activation runs to torque off regardless
// - default: instance 1 ready, 2 and 3 unused
// - dwell default 1 ms, window default 1
module rmss_top #(
    parameter NINST = 3,
    parameter VW = 16,
    parameter MS_CYC = `RMSS_MS_CYC,
    parameter DISC_MS = `RMSS_DISC_MS
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // axis and request inputs
    input wire signed [VW-1:0] safe_velocity,
    input wire [NINST-1:0] safe_input_req,
    input wire [1:0] dual_input,
    input wire fault_reaction,
    // status outputs
    output reg [NINST-1:0] stop_active_status,
    output reg [NINST-1:0] torque_off,
    output reg [NINST-1:0] safe_out,
    output reg io_fail_warn,
    output reg irq
);
    reg rst_s1_r;
    reg rst_n_r;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    reg [31:0] ctrl_r;
    reg [15:0] stop_to_r;
    reg [15:0] dwell_r;
    reg [15:0] zwin_r;
    reg [15:0] dlim_r;
    reg [15:0] ddly_r;
    reg [NINST-1:0] fbreq_r;
    reg [6:0] irq_stat_r;
    reg [6:0] irq_mask_r;
    reg [NINST-1:0] outmap_r;

    // millisecond tick shared by all timers
    reg [31:0] ms_cnt_r;
    reg ms_tick_r;
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ms_cnt_r <= 32'h0000_0000;
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == MS_CYC - 1) begin
            ms_cnt_r <= 32'h0000_0000;
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
            ms_tick_r <= 1'b0;
        end
    end

    // discrepancy supervisor on the dual input pair
    reg [15:0] disc_ms_r;
    reg io_fail_r;
    wire disc = dual_input[0] ^ dual_input[1];
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            disc_ms_r <= 16'h0000;
            io_fail_r <= 1'b0;
        end else if (!ctrl_r[`RMSS_CTRL_DUAL] || !disc) begin
            disc_ms_r <= 16'h0000;
            io_fail_r <= 1'b0;
        end else if (ms_tick_r) begin
            if (disc_ms_r > DISC_MS[15:0]) begin
                io_fail_r <= 1'b1;
            end else begin
                disc_ms_r <= disc_ms_r + 16'h0001;
            end
        end
    end

    // previous failure level: the interrupt event is the rise only, so a
    // write-one-to-clear sticks while the pair still disagrees
    reg io_fail_d_r;
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            io_fail_d_r <= 1'b0;
        end else begin
            io_fail_d_r <= io_fail_r;
        end
    end

    // per-instance request and state
    wire [NINST-1:0] req;
    wire [NINST-1:0] done_to;
    wire [NINST-1:0] done_dv;
    reg [NINST-1:0] act_r;
    reg [NINST-1:0] to_r;
    wire [NINST-1:0] used = ctrl_r[`RMSS_CTRL_USE_LSB +: NINST];

    genvar gi;
    generate
        for (gi = 0; gi < NINST; gi = gi + 1) begin : g_inst
            wire fb = fbreq_r[gi] & ctrl_r[`RMSS_CTRL_FB_EN];
            wire extra;
            if (gi == 0) begin : g_first
                assign extra = (fault_reaction & ctrl_r[`RMSS_CTRL_FR_SEL]) | io_fail_r;
            end else begin : g_other
                assign extra = 1'b0;
            end
            assign req[gi] = used[gi] & (fb | safe_input_req[gi] | extra);

            reg [15:0] t_r;
            reg [15:0] z_r;
            reg signed [VW-1:0] vprev_r;
            wire mon = ctrl_r[`RMSS_CTRL_MON_LSB + gi];
            // one extra bit so the magnitude of the most negative value fits
            wire signed [VW:0] vext = {safe_velocity[VW-1], safe_velocity};
            wire signed [VW:0] vmag = vext[VW] ? -vext : vext;
            wire in_zero = vmag <= $signed({1'b0, zwin_r});
            wire signed [VW:0] dv = {vprev_r[VW-1], vprev_r} - vext;
            wire signed [VW:0] dmag = dv[VW] ? -dv : dv;
            wire decel_bad = mon && (t_r >= ddly_r)
                && (dmag > $signed({1'b0, dlim_r}));
            wire dwell_ok = mon && in_zero && (z_r >= dwell_r);
            wire tout = t_r >= stop_to_r;
            assign done_to[gi] = act_r[gi] && !to_r[gi] && tout;
            assign done_dv[gi] = act_r[gi] && !to_r[gi] && decel_bad;

            always @(posedge mclk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    act_r[gi] <= 1'b0;
                    to_r[gi] <= 1'b0;
                    t_r <= 16'h0000;
                    z_r <= 16'h0000;
                    vprev_r <= {VW{1'b0}};
                end else begin
                    vprev_r <= safe_velocity;
                    if (!act_r[gi]) begin
                        if (req[gi]) begin
                            act_r[gi] <= 1'b1;
                            to_r[gi] <= 1'b0;
                            t_r <= 16'h0000;
                            z_r <= 16'h0000;
                        end
                    end else if (!to_r[gi]) begin
                        if (tout || dwell_ok || decel_bad) begin
                            to_r[gi] <= 1'b1;
                        end else if (ms_tick_r) begin
                            t_r <= t_r + 16'h0001;
                            z_r <= in_zero ? z_r + 16'h0001 : 16'h0000;
                        end else if (!in_zero) begin
                            z_r <= 16'h0000;
                        end
                    end else if (!req[gi]) begin
                        // stays in torque off while requested, rearms after
                        act_r[gi] <= 1'b0;
                        to_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // register port and interrupts
    wire [6:0] ev = {done_dv, done_to, io_fail_r & ~io_fail_d_r};
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= `RMSS_CTRL_RST;
            stop_to_r <= `RMSS_STOP_TO_MS;
            dwell_r <= `RMSS_DWELL_MS;
            zwin_r <= `RMSS_ZWIN_RST;
            dlim_r <= `RMSS_DLIM_RST;
            ddly_r <= `RMSS_DDLY_MS;
            fbreq_r <= {NINST{1'b0}};
            irq_stat_r <= 7'h00;
            irq_mask_r <= 7'h00;
            outmap_r <= {NINST{1'b0}};
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `RMSS_REG_CTRL: ctrl_r <= reg_wdata;
                    `RMSS_REG_STOP_TO: stop_to_r <= reg_wdata[15:0];
                    `RMSS_REG_DWELL: dwell_r <= reg_wdata[15:0];
                    `RMSS_REG_ZWIN: zwin_r <= reg_wdata[15:0];
                    `RMSS_REG_DLIM: dlim_r <= reg_wdata[15:0];
                    `RMSS_REG_DDLY: ddly_r <= reg_wdata[15:0];
                    `RMSS_REG_FBREQ: fbreq_r <= reg_wdata[NINST-1:0];
                    `RMSS_REG_IRQ_MASK: irq_mask_r <= reg_wdata[6:0];
                    `RMSS_REG_OUTMAP: outmap_r <= reg_wdata[NINST-1:0];
                    default: ;
                endcase
            end
            // set wins over write-one-to-clear
            if (reg_wr && reg_addr == `RMSS_REG_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata[6:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `RMSS_REG_CTRL: reg_rdata <= ctrl_r;
                    `RMSS_REG_STOP_TO: reg_rdata <= {16'h0000, stop_to_r};
                    `RMSS_REG_DWELL: reg_rdata <= {16'h0000, dwell_r};
                    `RMSS_REG_ZWIN: reg_rdata <= {16'h0000, zwin_r};
                    `RMSS_REG_DLIM: reg_rdata <= {16'h0000, dlim_r};
                    `RMSS_REG_DDLY: reg_rdata <= {16'h0000, ddly_r};
                    `RMSS_REG_FBREQ: reg_rdata <= {{(32-NINST){1'b0}}, fbreq_r};
                    `RMSS_REG_STATUS: reg_rdata <= {24'h000000, io_fail_r,
                        1'b0, to_r, act_r};
                    `RMSS_REG_IRQ_STAT: reg_rdata <= {25'h0000000, irq_stat_r};
                    `RMSS_REG_IRQ_MASK: reg_rdata <= {25'h0000000, irq_mask_r};
                    `RMSS_REG_OUTMAP: reg_rdata <= {{(32-NINST){1'b0}}, outmap_r};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    // registered outputs
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stop_active_status <= {NINST{1'b0}};
            torque_off <= {NINST{1'b0}};
            safe_out <= {NINST{1'b0}};
            io_fail_warn <= 1'b0;
            irq <= 1'b0;
        end else begin
            stop_active_status <= act_r;
            torque_off <= to_r;
            safe_out <= act_r & outmap_r;
            io_fail_warn <= io_fail_r;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule

// File: bench/rmss_checker.sv
// rmss_checker.sv: port assertions for the stop monitor
// assumes one clock, mclk, and the async reset arst_n
module rmss_checker #(
    parameter NINST = 3,
    parameter MS_CYC = 10,
    parameter DISC_MS = 100
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // watched ports
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire [1:0] dual_input,
    input wire fault_reaction,
    input wire [NINST-1:0] stop_active_status,
    input wire [NINST-1:0] torque_off,
    input wire [NINST-1:0] safe_out,
    input wire io_fail_warn
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO_MAX = 6 * MS_CYC;
    // run length three samples before the warning rises must already reach one cycle short of the limit
    localparam int DMIN = DISC_MS * MS_CYC - 1;
    int dis_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // run length of disagreement on the input pair
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) dis_r <= 0;
        else dis_r <= (dual_input[0] ^ dual_input[1]) ? dis_r + 1 : 0;
    end
    property p_to_act; (torque_off & ~$past(torque_off) & ~stop_active_status) == 0; endproperty
    a_to_act: assert property (p_to_act) else $error("torque off while idle");
    property p_timeout; $rose(stop_active_status[0]) |-> ##[1:TO_MAX] torque_off[0]; endproperty
    a_timeout: assert property (p_timeout) else $error("no torque off in time");
    property p_hold;
        ($past(stop_active_status) & ~stop_active_status & ~$past(torque_off)) == 0;
    endproperty
    a_hold: assert property (p_hold) else $error("stop dropped early");
    property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
    property p_out_map;
        (safe_out & ~stop_active_status & ~$past(stop_active_status)) == 0;
    endproperty
    a_out_map: assert property (p_out_map) else $error("output without stop");
    property p_disc_time; $rose(io_fail_warn) |-> $past(dis_r, 3) >= DMIN; endproperty
    a_disc_time: assert property (p_disc_time) else $error("failure too soon");
    property p_disc_act; $rose(io_fail_warn) |-> ##[0:4] stop_active_status[0]; endproperty
    a_disc_act: assert property (p_disc_act) else $error("failure left stop idle");
    property p_fault_act; $rose(fault_reaction) |-> ##[1:3] stop_active_status[0]; endproperty
    a_fault_act: assert property (p_fault_act) else $error("fault not taken");
    c_to: cover property ($rose(torque_off[0]));
    c_fail: cover property ($rose(io_fail_warn));
    c_inst: cover property ($rose(stop_active_status[1]));
endmodule

// File: bench/rmss_partner.sv
// rmss_partner.sv: safe feedback model of a braking axis
// assumes loads come from the bench on mclk edges
module rmss_partner (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // ramp control
    input wire signed [15:0] vel_set,
    input wire signed [15:0] vel_step,
    input wire vel_load,
    // velocity to the monitor
    output logic signed [15:0] safe_velocity
);
    timeunit 1ns;
    timeprecision 1ns;
    // falls by vel_step each clock and settles at zero
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) safe_velocity <= 16'sh0000;
        else if (vel_load) safe_velocity <= vel_set;
        else safe_velocity <= (safe_velocity > vel_step) ? safe_velocity - vel_step : 16'sh0000;
    end
endmodule

// File: bench/test_rmss_top.sv
// test_rmss_top.sv: self-checking bench for the stop monitor
// assumes ms ticks of 10 clocks and the velocity partner
module test_rmss_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, fault_reaction = 0, vel_load = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [2:0] safe_input_req = 3'h0;
    logic [1:0] dual_input = 2'h0;
    logic signed [15:0] vel_set = 16'sh0, vel_step = 16'sh0;
    wire [31:0] reg_rdata;
    wire signed [15:0] safe_velocity;
    wire [2:0] stop_active_status, torque_off, safe_out;
    wire io_fail_warn, irq;
    wire [7:0] obs = {irq, io_fail_warn, torque_off, stop_active_status};
    int errors = 0, n_checks = 0, n;
    always #5 mclk = ~mclk;
    rmss_partner pm (.mclk(mclk), .arst_n(arst_n), .vel_set(vel_set), .vel_step(vel_step),
        .vel_load(vel_load), .safe_velocity(safe_velocity));
    rmss_top #(.MS_CYC(10), .DISC_MS(3)) uut (
        .mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .safe_velocity(safe_velocity), .safe_input_req(safe_input_req),
        .dual_input(dual_input), .fault_reaction(fault_reaction),
        .stop_active_status(stop_active_status), .torque_off(torque_off),
        .safe_out(safe_out), .io_fail_warn(io_fail_warn), .irq(irq));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    task automatic put(input logic [2:0] r, input logic f, input logic [1:0] d);
        @(posedge mclk);
        safe_input_req <= r;
        fault_reaction <= f;
        dual_input <= d;
    endtask
    // waits for one observed bit, bounded; n holds the cycles taken
    task automatic wait_for(input int sel, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (obs[sel] !== v && n < lim);
        cmp(32'(obs[sel]), 32'(v));
        if (obs[sel] !== v) close_out();
    endtask
    task automatic t_regs();
        logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30};
        logic [31:0] e [7] = '{32'h104, 32'h2, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0};
        wr(8'h30, 32'hFFFF);
        for (int i = 0; i < 7; i++) rd(a[i], e[i]);
        $display("test regs done");
    endtask
    task automatic t_timeout();
        wr(8'h04, 32'h5);
        put(3'h1, 1'b0, 2'h0);
        put(3'h0, 1'b0, 2'h0);
        wait_for(0, 1, 5);
        wait_for(3, 1, 70);
        cmp(32'(n >= 38 && n <= 53), 32'h1);
        rd(8'h20, 32'h2);
        cmp(32'(irq), 32'h0);
        wr(8'h24, 32'h2);
        wait_for(7, 1, 4);
        wr(8'h20, 32'h2);
        wait_for(7, 0, 4);
        wait_for(0, 0, 5);
        $display("test timeout done");
    endtask
    task automatic t_ramp();
        wr(8'h04, 32'h32);
        wr(8'h00, 32'h124);
        put(3'h1, 1'b0, 2'h0);
        wait_for(3, 1, 25);
        rd(8'h20, 32'h0);
        put(3'h0, 1'b0, 2'h0);
        wait_for(0, 0, 5);
        wr(8'h10, 32'h2);
        @(posedge mclk);
        vel_set <= 16'sh03E8;
        vel_step <= 16'sh0005;
        vel_load <= 1'b1;
        put(3'h1, 1'b0, 2'h0);
        vel_load <= 1'b0;
        wait_for(3, 1, 30);
        rd(8'h20, 32'h10);
        put(3'h0, 1'b0, 2'h0);
        wait_for(0, 0, 5);
        $display("test ramp done");
    endtask
    task automatic t_bus();
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h101);
        wr(8'h28, 32'h2);
        wr(8'h18, 32'h6);
        repeat (8) @(posedge mclk);
        #1 cmp(32'(stop_active_status), 32'h0);
        wr(8'h00, 32'h11D);
        wait_for(2, 1, 5);
        repeat (2) @(posedge mclk);
        #1 cmp({stop_active_status, safe_out}, 32'h32);
        wr(8'h18, 32'h0);
        wait_for(1, 0, 30);
        wait_for(2, 0, 5);
        $display("test bus done");
    endtask
    task automatic t_faults();
        wr(8'h00, 32'h106);
        put(3'h0, 1'b0, 2'h1);
        wait_for(6, 1, 60);
        cmp(32'(n > 30), 32'h1);
        rd(8'h20, 32'h1D);
        wr(8'h20, 32'h7F);
        rd(8'h20, 32'h0);
        wait_for(0, 1, 5);
        wait_for(3, 1, 30);
        put(3'h0, 1'b0, 2'h0);
        wait_for(6, 0, 5);
        wait_for(0, 0, 5);
        put(3'h0, 1'b1, 2'h0);
        wait_for(0, 1, 4);
        wait_for(3, 1, 30);
        put(3'h0, 1'b0, 2'h0);
        wait_for(0, 0, 5);
        $display("test faults done");
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs();
        t_timeout();
        t_ramp();
        t_bus();
        t_faults();
        close_out();
    end
endmodule
bind rmss_top rmss_checker #(.NINST(NINST), .MS_CYC(MS_CYC), .DISC_MS(DISC_MS)) chk (
    .mclk(mclk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dual_input(dual_input), .fault_reaction(fault_reaction),
    .stop_active_status(stop_active_status), .torque_off(torque_off), .safe_out(safe_out),
    .io_fail_warn(io_fail_warn));
